//--- include/pcg_pkg.sv
package pcg_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTL  = 12'h100;
  localparam logic [11:0] OFF_MULT = 12'h110;
  localparam logic [11:0] OFF_PRE  = 12'h114;
  localparam logic [11:0] OFF_DIV1 = 12'h118;
  localparam logic [11:0] OFF_DIV2 = 12'h11C;
  localparam logic [11:0] OFF_DIV3 = 12'h120;
  localparam logic [11:0] OFF_POST = 12'h128;
  localparam logic [11:0] OFF_BP   = 12'h12C;
  localparam logic [11:0] OFF_CMD  = 12'h138;
  localparam logic [11:0] OFF_STAT = 12'h13C;
  localparam logic [11:0] OFF_DIV4 = 12'h160;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EN_BIT       = 15;
  localparam int SEL_BIT      = 0;
  localparam int GO_BIT       = 0;
  localparam int STAT_GO_BIT  = 0;
  localparam int STAT_SEL_BIT = 1;

  typedef logic [4:0] pcg_ratio_t;

  // ----------------------------------------------------------------
  // reference model and fixed ratios (field value n = divide n+1)
  // ----------------------------------------------------------------
  localparam int         REF_SHIFT   = 5;
  localparam logic [4:0] REF_LAST    = 5'h1F;
  localparam pcg_ratio_t PRE_FIX_MAIN = 5'h07;
  localparam pcg_ratio_t D1_FIX_MAIN = 5'h01;
  localparam pcg_ratio_t D1_FIX_MEM  = 5'h00;
  localparam pcg_ratio_t D2_FIX      = 5'h03;
  localparam pcg_ratio_t D4_SLOW     = 5'h03;
  localparam pcg_ratio_t D4_FAST     = 5'h01;
  localparam pcg_ratio_t BP_FIX_MAIN = 5'h02;
  localparam pcg_ratio_t BP_FIX_MEM  = 5'h07;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam pcg_ratio_t PRE_RST  = 5'h00;
  localparam pcg_ratio_t MULT_RST = 5'h00;
  localparam pcg_ratio_t POST_RST = 5'h00;
  localparam pcg_ratio_t DIV_RST  = 5'h00;

  typedef enum logic [1:0] {
    PCG_IDLE = 2'b01,
    PCG_HOLD = 2'b10
  } pcg_state_e;

endpackage

//--- src/pcg_clock_ctrl.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------
// domain divider
// ------------------------------------------------------------------
module pcg_domain_div (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               edge_i,
  input  wire logic               en_i,
  input  wire logic               freeze_i,
  input  wire logic               load_i,
  input  wire pcg_pkg::pcg_ratio_t ratio_i,
  output logic                    clk_q
);
  pcg_pkg::pcg_ratio_t cnt_q;
  logic                stall;
  logic                wrap;

  // paused only while low, so a high phase always completes
  assign stall = freeze_i & ~clk_q;
  assign wrap  = (cnt_q >= ratio_i);

  // toggle per ratio+1 edges, two edges per source period
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= 5'h00;
      clk_q <= 1'b0;
    end
    else if (load_i || !en_i)
    begin
      cnt_q <= 5'h00;
      clk_q <= 1'b0;
    end
    else if (edge_i && !stall)
    begin
      cnt_q <= wrap ? 5'h00 : cnt_q + 5'h01;
      clk_q <= wrap ? ~clk_q : clk_q;
    end
  end

  property p_half_period;
    @(posedge hclk) disable iff (!hresetn)
    (cnt_q <= ratio_i);
  endproperty
  a_half_period: assert property (p_half_period)
    else $error("domain divider count passed its ratio");

endmodule

// ------------------------------------------------------------------
// clock controller top
// ------------------------------------------------------------------
module pcg_clock_ctrl #(
  parameter bit MAIN_INST = 1'b1
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic [3:0]       domain_clock,
  output logic             auxiliary_clock,
  output logic             first_clock_output_pin,
  output logic             second_clock_output_pin,
  output logic             third_clock_output_pin
);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic        wr_q;
  logic [11:0] waddr_q;
  logic [31:0] rdata_q;
  logic        take;
  logic [11:0] raddr;
  logic [31:0] rd_data;

  // size ignored: every access is treated as a whole word
  assign take  = hsel & htrans[1] & hready;
  assign raddr = haddr[11:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q    <= 1'b0;
      waddr_q <= 12'h000;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_q    <= take & hwrite;
      waddr_q <= raddr;
      rdata_q <= (take && !hwrite) ? rd_data : rdata_q;
    end
  end

  assign hrdata = rdata_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic                sel_req_q;
  logic                sel_act_q;
  pcg_pkg::pcg_ratio_t mult_q;
  pcg_pkg::pcg_ratio_t pre_q;
  logic                pre_en_q;
  pcg_pkg::pcg_ratio_t post_q;
  logic                post_en_q;
  logic                bp_en_q;
  logic                go_pend_q;
  logic                den_q [4];
  logic [3:0]          den_eff;
  pcg_pkg::pcg_ratio_t dratio_q [4];
  pcg_pkg::pcg_ratio_t ract_q [4];
  pcg_pkg::pcg_ratio_t d_eff [4];
  pcg_pkg::pcg_ratio_t pre_eff;
  pcg_pkg::pcg_ratio_t post_eff;
  pcg_pkg::pcg_ratio_t bp_fix;
  logic                wr_ctl;
  logic                wr_mult;
  logic                wr_pre;
  logic                wr_post;
  logic                wr_bp;
  logic                wr_go;
  logic [3:0]          wr_div;
  logic                apply;

  assign wr_ctl    = wr_q & (waddr_q == pcg_pkg::OFF_CTL);
  assign wr_mult   = wr_q & (waddr_q == pcg_pkg::OFF_MULT);
  assign wr_pre    = wr_q & (waddr_q == pcg_pkg::OFF_PRE);
  assign wr_post   = wr_q & (waddr_q == pcg_pkg::OFF_POST);
  assign wr_bp     = wr_q & (waddr_q == pcg_pkg::OFF_BP);
  assign wr_go     = wr_q & (waddr_q == pcg_pkg::OFF_CMD)
                     & hwdata[pcg_pkg::GO_BIT];
  assign wr_div[0] = wr_q & (waddr_q == pcg_pkg::OFF_DIV1);
  assign wr_div[1] = wr_q & (waddr_q == pcg_pkg::OFF_DIV2);
  assign wr_div[2] = wr_q & (waddr_q == pcg_pkg::OFF_DIV3);
  assign wr_div[3] = wr_q & (waddr_q == pcg_pkg::OFF_DIV4);

  assign pre_eff  = MAIN_INST ? pcg_pkg::PRE_FIX_MAIN : pre_q;
  assign post_eff = MAIN_INST ? {4'h0, post_q[0]} : 5'h00;
  assign bp_fix   = MAIN_INST ? pcg_pkg::BP_FIX_MAIN : pcg_pkg::BP_FIX_MEM;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sel_req_q <= 1'b0;
      mult_q    <= pcg_pkg::MULT_RST;
      pre_q     <= pcg_pkg::PRE_RST;
      pre_en_q  <= 1'b1;
      post_q    <= pcg_pkg::POST_RST;
      post_en_q <= 1'b1;
      bp_en_q   <= 1'b1;
      go_pend_q <= 1'b0;
    end
    else
    begin
      sel_req_q <= wr_ctl ? hwdata[pcg_pkg::SEL_BIT] : sel_req_q;
      mult_q    <= wr_mult ? hwdata[4:0] : mult_q;
      pre_q     <= wr_pre ? hwdata[4:0] : pre_q;
      pre_en_q  <= wr_pre ? hwdata[pcg_pkg::EN_BIT] : pre_en_q;
      post_q    <= wr_post ? hwdata[4:0] : post_q;
      post_en_q <= wr_post ? hwdata[pcg_pkg::EN_BIT] : post_en_q;
      bp_en_q   <= wr_bp ? hwdata[pcg_pkg::EN_BIT] : bp_en_q;
      // a new command in the apply cycle is kept
      go_pend_q <= wr_go | (go_pend_q & ~apply);
    end
  end

  function automatic logic [31:0] fld(input logic en,
                                      input pcg_pkg::pcg_ratio_t r);
    fld = ({31'h0000_0000, en} << pcg_pkg::EN_BIT) | {27'h0000000, r};
  endfunction

  logic [31:0] stat_word;

  assign stat_word = ({31'h0000_0000, go_pend_q} << pcg_pkg::STAT_GO_BIT)
                   | ({31'h0000_0000, sel_act_q} << pcg_pkg::STAT_SEL_BIT);

  assign rd_data =
    (raddr == pcg_pkg::OFF_CTL)  ? {31'h0000_0000, sel_req_q} :
    (raddr == pcg_pkg::OFF_MULT) ? {27'h0000000, mult_q} :
    (raddr == pcg_pkg::OFF_PRE)  ? fld(pre_en_q, pre_eff) :
    (raddr == pcg_pkg::OFF_POST) ? fld(post_en_q, post_eff) :
    (raddr == pcg_pkg::OFF_BP)   ? fld(bp_en_q, bp_fix) :
    (raddr == pcg_pkg::OFF_STAT) ? stat_word :
    (raddr == pcg_pkg::OFF_DIV1) ? fld(den_eff[0], d_eff[0]) :
    (raddr == pcg_pkg::OFF_DIV2) ? fld(den_eff[1], d_eff[1]) :
    (raddr == pcg_pkg::OFF_DIV3) ? fld(den_eff[2], d_eff[2]) :
    (raddr == pcg_pkg::OFF_DIV4) ? fld(den_eff[3], d_eff[3]) :
    32'h0000_0000;

  // ----------------------------------------------------------------
  // reference and pll path
  // ----------------------------------------------------------------
  logic [4:0]  rcnt_q;
  logic        ref_edge_q;
  logic [10:0] acc_q;
  logic [10:0] modulus;
  logic [11:0] acc_sum;
  logic        hit;
  logic        pll_edge_q;
  pcg_pkg::pcg_ratio_t pcnt_q;
  logic        post_edge_q;
  logic        src_edge;

  // each instance counts its own reference edge stream
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rcnt_q     <= 5'h00;
      ref_edge_q <= 1'b0;
    end
    else
    begin
      rcnt_q     <= rcnt_q + 5'h01;
      ref_edge_q <= (rcnt_q == pcg_pkg::REF_LAST);
    end
  end

  // pre-division folded into the oscillator modulus
  assign modulus = ({6'h00, pre_eff} + 11'h001) << pcg_pkg::REF_SHIFT;
  // multiplier field n adds n+1 per cycle
  assign acc_sum = {1'b0, acc_q} + {7'h00, mult_q} + 12'h001;
  assign hit     = (acc_sum >= {1'b0, modulus});

  // rate capped at one edge per cycle; a stale phase restarts cleanly
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc_q      <= 11'h000;
      pll_edge_q <= 1'b0;
    end
    else if (!pre_en_q || acc_q >= modulus)
    begin
      acc_q      <= 11'h000;
      pll_edge_q <= 1'b0;
    end
    else
    begin
      acc_q      <= hit ? 11'(acc_sum - {1'b0, modulus}) : acc_sum[10:0];
      pll_edge_q <= hit;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pcnt_q      <= 5'h00;
      post_edge_q <= 1'b0;
    end
    else if (!post_en_q)
    begin
      pcnt_q      <= 5'h00;
      post_edge_q <= 1'b0;
    end
    else
    begin
      if (pll_edge_q)
        pcnt_q <= (pcnt_q >= post_eff) ? 5'h00 : pcnt_q + 5'h01;
      post_edge_q <= pll_edge_q & (pcnt_q >= post_eff);
    end
  end

  assign src_edge = sel_act_q ? post_edge_q : ref_edge_q;

  // ----------------------------------------------------------------
  // switch sequencer
  // ----------------------------------------------------------------
  pcg_pkg::pcg_state_e st_q;
  pcg_pkg::pcg_state_e st_d;
  logic                hold_req;
  logic                all_low;
  logic                freeze;

  assign hold_req = (sel_req_q != sel_act_q) | go_pend_q;
  assign all_low  = ~|domain_clock;
  assign freeze   = (st_q == pcg_pkg::PCG_HOLD);
  // switch only once every domain clock rests low
  assign apply    = freeze & all_low;

  always_comb
  begin
    case (st_q)
      pcg_pkg::PCG_IDLE: st_d = hold_req ? pcg_pkg::PCG_HOLD
                                         : pcg_pkg::PCG_IDLE;
      pcg_pkg::PCG_HOLD: st_d = apply ? pcg_pkg::PCG_IDLE
                                      : pcg_pkg::PCG_HOLD;
      default:           st_d = pcg_pkg::PCG_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q      <= pcg_pkg::PCG_IDLE;
      sel_act_q <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      sel_act_q <= apply ? sel_req_q : sel_act_q;
    end
  end

  // ----------------------------------------------------------------
  // domain dividers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++)
  begin : g_dom
    // fixed domain one and two ratios
    // domain three free, domain four /2 or /4
    localparam pcg_pkg::pcg_ratio_t RST_RATIO =
      (i == 0) ? (MAIN_INST ? pcg_pkg::D1_FIX_MAIN : pcg_pkg::D1_FIX_MEM) :
      (i == 1) ? pcg_pkg::D2_FIX :
      (i == 2) ? pcg_pkg::DIV_RST : pcg_pkg::D4_SLOW;

    // field n means divide by n+1
    assign d_eff[i] =
      (i == 0) ? (MAIN_INST ? pcg_pkg::D1_FIX_MAIN : pcg_pkg::D1_FIX_MEM) :
      (i == 1) ? pcg_pkg::D2_FIX :
      (i == 2) ? dratio_q[i] :
      ((dratio_q[i] == pcg_pkg::D4_FAST) ? pcg_pkg::D4_FAST
                                         : pcg_pkg::D4_SLOW);

    // memory instance keeps only domain one
    assign den_eff[i] = den_q[i] & (MAIN_INST | (i == 0));

    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        den_q[i]    <= 1'b1;
        dratio_q[i] <= pcg_pkg::DIV_RST;
        ract_q[i]   <= RST_RATIO;
      end
      else
      begin
        den_q[i]    <= wr_div[i] ? hwdata[pcg_pkg::EN_BIT] : den_q[i];
        dratio_q[i] <= wr_div[i] ? hwdata[4:0] : dratio_q[i];
        // ratio loads only with the command
        ract_q[i]   <= (apply && go_pend_q) ? d_eff[i] : ract_q[i];
      end
    end

    pcg_domain_div u_div (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .edge_i   (src_edge),
      .en_i     (den_eff[i]),
      .freeze_i (freeze),
      .load_i   (apply),
      .ratio_i  (ract_q[i]),
      .clk_q    (domain_clock[i])
    );
  end

  // ----------------------------------------------------------------
  // bypass and auxiliary clocks
  // ----------------------------------------------------------------
  pcg_pkg::pcg_ratio_t bcnt_q;
  logic                bp_clk_q;
  logic                bp_wrap;
  logic                bp_nxt;

  assign bp_wrap = ref_edge_q & (bcnt_q >= bp_fix);
  assign bp_nxt  = bp_en_q & (bp_wrap ? ~bp_clk_q : bp_clk_q);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bcnt_q                  <= 5'h00;
      bp_clk_q                <= 1'b0;
      second_clock_output_pin <= 1'b0;
      third_clock_output_pin  <= 1'b0;
      auxiliary_clock         <= 1'b0;
      first_clock_output_pin  <= 1'b0;
    end
    else
    begin
      // bypass edges counted on the reference
      if (!bp_en_q)
        bcnt_q <= 5'h00;
      else if (ref_edge_q)
        bcnt_q <= bp_wrap ? 5'h00 : bcnt_q + 5'h01;
      bp_clk_q                <= bp_nxt;
      second_clock_output_pin <= MAIN_INST ? bp_nxt : 1'b0;
      third_clock_output_pin  <= MAIN_INST ? 1'b0 : bp_nxt;
      // undivided reference, unused on memory instance
      auxiliary_clock         <= MAIN_INST & (auxiliary_clock ^ ref_edge_q);
      first_clock_output_pin  <= MAIN_INST &
                                 (first_clock_output_pin ^ ref_edge_q);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_mode_pending;
    @(posedge hclk) disable iff (!hresetn)
    (sel_act_q != sel_req_q) |-> ##[0:1] (st_q == pcg_pkg::PCG_HOLD);
  endproperty
  a_mode_pending: assert property (p_mode_pending)
    else $error("mode change not taken up");

  property p_bypass_src;
    @(posedge hclk) disable iff (!hresetn)
    (!sel_act_q && $rose(ref_edge_q)) |-> src_edge;
  endproperty
  a_bypass_src: assert property (p_bypass_src)
    else $error("bypass does not follow reference");

  property p_rise_from_req;
    @(posedge hclk) disable iff (!hresetn)
    $rose(sel_act_q) |-> $past(sel_req_q) && $past(freeze);
  endproperty
  a_rise_from_req: assert property (p_rise_from_req)
    else $error("pll mode entered without request");

  property p_disabled_low;
    @(posedge hclk) disable iff (!hresetn)
    (~den_eff & ~$past(den_eff) & domain_clock) == 4'h0;
  endproperty
  a_disabled_low: assert property (p_disabled_low)
    else $error("disabled domain clock toggles");

  property p_pre_gate;
    @(posedge hclk) disable iff (!hresetn)
    (!pre_en_q) [*3] |-> !post_edge_q;
  endproperty
  a_pre_gate: assert property (p_pre_gate)
    else $error("edges with pre-divider off");

  property p_post_gate;
    @(posedge hclk) disable iff (!hresetn)
    (!post_en_q) [*2] |-> !post_edge_q;
  endproperty
  a_post_gate: assert property (p_post_gate)
    else $error("edges with post-divider off");

  property p_switch_low;
    @(posedge hclk) disable iff (!hresetn)
    $changed(sel_act_q) |-> ($past(domain_clock) == 4'h0);
  endproperty
  a_switch_low: assert property (p_switch_low)
    else $error("mode switched with a clock high");

  property p_ratio_cmd;
    @(posedge hclk) disable iff (!hresetn)
    $changed(ract_q[2]) |-> $past(go_pend_q) && $past(all_low);
  endproperty
  a_ratio_cmd: assert property (p_ratio_cmd)
    else $error("ratio changed without command");

  property p_bp_count;
    @(posedge hclk) disable iff (!hresetn)
    (bcnt_q <= bp_fix);
  endproperty
  a_bp_count: assert property (p_bp_count)
    else $error("bypass count passed its ratio");

endmodule

//--- testbench/pcg_clk_sink.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// clock consumer: times one selected clock in hclk cycles
// ------------------------------------------------------------
module pcg_clk_sink (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [15:0] clk_in,
  input  wire logic [3:0]  sel,
  output logic      [15:0] period_q,
  output logic      [15:0] high_q,
  output logic      [15:0] rises_q
);
  logic        prev_q;
  logic [15:0] cnt_q;
  logic [15:0] hcnt_q;
  wire  logic  cur  = clk_in[sel];
  wire  logic  rise = cur & ~prev_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_q   <= 1'b0;
      cnt_q    <= 16'h0000;
      hcnt_q   <= 16'h0000;
      period_q <= 16'h0000;
      high_q   <= 16'h0000;
      rises_q  <= 16'h0000;
    end
    else
    begin
      prev_q <= cur;
      cnt_q  <= rise ? 16'h0001 : cnt_q + 16'h0001;
      hcnt_q <= rise ? 16'h0001 : hcnt_q + {15'h0000, cur};
      if (rise)
      begin
        period_q <= cnt_q;
        high_q   <= hcnt_q;
        rises_q  <= rises_q + 16'h0001;
      end
    end
  end
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  sel, mdclk;
  logic        maux, mp1, mp2, mp3;
  logic        hreadyout, hresp, aux, p1, p2, p3;
  logic [3:0]  dclk;
  logic [15:0] per, hi, rises, r0;
  int          fails, cmp_count, cyc;

  pcg_clock_ctrl #(.MAIN_INST(1'b1)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .domain_clock(dclk), .auxiliary_clock(aux),
    .first_clock_output_pin(p1), .second_clock_output_pin(p2),
    .third_clock_output_pin(p3));

  // memory instance stays at its reset settings; the bus never selects it
  pcg_clock_ctrl #(.MAIN_INST(1'b0)) dut_mem (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b0), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(),
    .domain_clock(mdclk), .auxiliary_clock(maux),
    .first_clock_output_pin(mp1), .second_clock_output_pin(mp2),
    .third_clock_output_pin(mp3));

  pcg_clk_sink sink (
    .hclk(hclk), .hresetn(hresetn),
    .clk_in({mp3, mp2, mp1, maux, mdclk, p3, p2, p1, aux, dclk}),
    .sel(sel), .period_q(per), .high_q(hi), .rises_q(rises));

  // ----------------------------------------------------------
  // clock, timeout, checks
  // ----------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // longest path is about 10k cycles of clock timing
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] g, e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  // ----------------------------------------------------------
  // bus cycle: hold address until hready, then data phase
  // ----------------------------------------------------------
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h00000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("response", {31'h00000000, hresp}, 32'h00000000);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk("register", rd, e);
  endtask

  task automatic stat_wait(input int b, input logic v);
    do bus(1'b0, pcg_pkg::OFF_STAT, 32'h00000000); while (rd[b] !== v);
  endtask

  // waits three rises so a stale period is never taken
  task automatic meas(input logic [3:0] s, input logic [15:0] p);
    sel <= s;
    @(posedge hclk);
    r0 = rises;
    while (rises - r0 < 16'h0003) @(posedge hclk);
    chk("period", {16'h0000, per}, {16'h0000, p});
    chk("high", {16'h0000, hi}, {17'h00000, p[15:1]});
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    sel = 3'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rdchk(pcg_pkg::OFF_CTL, 32'h00000000);
    rdchk(pcg_pkg::OFF_STAT, 32'h00000000);
    rdchk(pcg_pkg::OFF_PRE, 32'h00008007);
    rdchk(pcg_pkg::OFF_POST, 32'h00008000);
    rdchk(pcg_pkg::OFF_DIV1, 32'h00008001);
    rdchk(pcg_pkg::OFF_DIV2, 32'h00008003);
    rdchk(pcg_pkg::OFF_BP, 32'h00008002);
    rdchk(12'h200, 32'h00000000);
    $display("reset test done");
    // reference period is 64 hclk cycles
    meas(4'h0, 16'h0080);
    meas(4'h1, 16'h0100);
    meas(4'h2, 16'h0040);
    meas(4'h3, 16'h0100);
    meas(4'h4, 16'h0040);
    meas(4'h5, 16'h0040);
    meas(4'h6, 16'h00C0);
    chk("third pin", {31'h0, p3}, 32'h00000000);
    $display("bypass test done");
    meas(4'h8, 16'h0040);
    meas(4'hF, 16'h0200);
    chk("memory domains", {29'h0, mdclk[3:1]}, 32'h00000000);
    chk("memory aux", {29'h0, maux, mp1, mp2}, 32'h00000000);
    $display("memory instance test done");
    bus(1'b1, pcg_pkg::OFF_DIV3, 32'h00008002);
    bus(1'b1, pcg_pkg::OFF_DIV4, 32'h00008001);
    meas(4'h2, 16'h0040);
    bus(1'b1, pcg_pkg::OFF_CMD, 32'h00000001);
    stat_wait(0, 1'b0);
    meas(4'h2, 16'h00C0);
    meas(4'h3, 16'h0080);
    $display("ratio change test done");
    bus(1'b1, pcg_pkg::OFF_DIV2, 32'h00000000);
    sel <= 4'h1;
    repeat (600) @(posedge hclk);
    r0 = rises;
    repeat (600) @(posedge hclk);
    chk("stopped clock", {16'h0000, rises}, {16'h0000, r0});
    chk("clock level", {31'h0, dclk[1]}, 32'h00000000);
    $display("disable test done");
    // x16 after fixed /8: source period 32 hclk
    bus(1'b1, pcg_pkg::OFF_MULT, 32'h0000000F);
    // modelled multiplier has no lock time
    bus(1'b1, pcg_pkg::OFF_CTL, 32'h00000001);
    repeat (8 << pcg_pkg::REF_SHIFT) @(posedge hclk);
    stat_wait(1, 1'b1);
    meas(4'h0, 16'h0040);
    meas(4'h2, 16'h0060);
    bus(1'b1, pcg_pkg::OFF_POST, 32'h00008001);
    meas(4'h0, 16'h0080);
    $display("pll mode test done");
    // back to bypass before the pll path is switched off
    bus(1'b1, pcg_pkg::OFF_CTL, 32'h00000000);
    repeat (8 << pcg_pkg::REF_SHIFT) @(posedge hclk);
    stat_wait(1, 1'b0);
    bus(1'b1, pcg_pkg::OFF_PRE, 32'h00000000);
    bus(1'b1, pcg_pkg::OFF_POST, 32'h00000000);
    rdchk(pcg_pkg::OFF_PRE, 32'h00000007);
    rdchk(pcg_pkg::OFF_POST, 32'h00000000);
    meas(4'h0, 16'h0080);
    $display("bypass return test done");
    summarize();
  end
endmodule
